// file: verilog/stm_consts.vh
// constants for the scan time monitor and device map
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
`define STM_CLK_HZ          20000000
`define STM_UNIT_MS         10
`define STM_WORD_W          16
`define STM_SIGN_BIT        15
`define STM_WORD_MAX        16'h7FFF
`define STM_WORD_MIN        16'h8000
`define STM_WORD_UMAX       16'hFFFF
`define STM_IN_POINTS       64
`define STM_IN_WIRED        12
`define STM_OUT_POINTS      64
`define STM_OUT_WIRED       7
`define STM_SPECIAL_POINTS  256
`define STM_TMR100_MAX      16'h7FFF
`define STM_TMR100_MIN      16'h0001
`define STM_TMR10_MAX       16'h7FFF
`define STM_TMR10_MIN       16'h0001
`define STM_CNT_MIN         16'h0001
`define STM_CNT_MAX         16'h7FFF
`define STM_RELAY_NORMAL    2'h0
`define STM_RELAY_LATCH     2'h1
`define STM_RELAY_STEP      2'h2
`define STM_TMR_100MS       2'h0
`define STM_TMR_10MS        2'h1
`define STM_TMR_RET100      2'h2
// register byte addresses
`define STM_ADR_MIN         8'h00
`define STM_ADR_PRESENT     8'h04
`define STM_ADR_MAX         8'h08
`define STM_ADR_STATUS      8'h0C
`define STM_ADR_CONFIG      8'h10
`define STM_ADR_SETVAL      8'h14
`define STM_ADR_INIMG       8'h18
`define STM_ADR_OUTIMG      8'h1C
`define STM_CFG_RESET       16'h0000
`define STM_STAT_VALID      0
`define STM_STAT_SETBAD     1
`endif

// file: verilog/stm_scan_monitor.v
// scan time monitor with wishbone registers and device map limits
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "stm_consts.vh"
// Function
// - time each scan from one end-of-program strobe to the next in 10ms units
// - keep the smallest scan time seen in a read-only register
// - keep the latest scan time in a read-only register
// - keep the largest scan time seen in a read-only register
// - measurement accuracy is one 10ms unit either way
// - every word register is 16 bits, msb is the sign
// - words hold signed values -32768 to 32767 in two's complement
// - seen unsigned, words hold 0 to FFFF
// - input image has 64 points, 12 wired to terminals
// - output image has 64 points, 7 drive terminals
// - latching relay setting accepted but behaves as non-latching
// - step relay setting accepted but behaves as internal relay
// - 100ms timer accepts 0.1 to 3276.7s as 16-bit tick count
// - 10ms timer accepts 0.01 to 327.67s as 16-bit tick count
// - retentive 100ms timer accepts 0.1 to 3276.7s
// - up counter accepts 1 to 32767; no interrupt counter type
// - special relay area spans 256 points, limited subset implemented
// - special register area spans 256 words, limited subset implemented
module stm_scan_monitor #(
  parameter integer CLK_HZ     = `STM_CLK_HZ,
  parameter integer UNIT_MS    = `STM_UNIT_MS,
  parameter integer IN_WIRED   = `STM_IN_WIRED,
  parameter integer OUT_WIRED  = `STM_OUT_WIRED
) (
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  scan_end_i,
  input  wire [IN_WIRED-1:0]   in_term_i,
  output reg  [OUT_WIRED-1:0]  out_term_o,
  output reg  [1:0]            relay_mode_o,
  output reg  [1:0]            timer_mode_o,
  output reg  [15:0]           set_value_o,
  input  wire                  wb_cyc_i,
  input  wire                  wb_stb_i,
  input  wire                  wb_we_i,
  input  wire [7:0]            wb_adr_i,
  input  wire [3:0]            wb_sel_i,
  input  wire [31:0]           wb_dat_i,
  output reg  [31:0]           wb_dat_o,
  output reg                   wb_ack_o
);

  // cycles per 10ms unit, derived from the clock rate
  localparam integer UNIT_CYC = (CLK_HZ / 1000) * UNIT_MS;
  localparam integer PRE_W    = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam [31:0]      PRE_LAST_W = UNIT_CYC - 1;
  localparam [PRE_W-1:0] PRE_LAST   = PRE_LAST_W[PRE_W-1:0];

  // prescaler: one-cycle pulse every 10ms
  reg  [PRE_W-1:0] pre_ff;
  wire             tick = (pre_ff == PRE_LAST);

  always @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_ff <= {PRE_W{1'b0}};
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // input synchroniser for terminal and scan end pins
  reg  [IN_WIRED:0] s1_ff;
  reg  [IN_WIRED:0] s2_ff;
  reg  [IN_WIRED:0] s3_ff;
  reg  [IN_WIRED:0] stable_ff;
  genvar gi;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= {(IN_WIRED+1){1'b0}};
      s2_ff <= {(IN_WIRED+1){1'b0}};
      s3_ff <= {(IN_WIRED+1){1'b0}};
    end else begin
      s1_ff <= {scan_end_i, in_term_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  generate
    for (gi = 0; gi <= IN_WIRED; gi = gi + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          stable_ff[gi] <= 1'b0;
        end else if (s2_ff[gi] == s3_ff[gi]) begin
          stable_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  reg  end_prev_ff;
  wire end_rise = stable_ff[IN_WIRED] & ~end_prev_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      end_prev_ff <= 1'b0;
    end else begin
      end_prev_ff <= stable_ff[IN_WIRED];
    end
  end

  // scan timing
  reg  [15:0] run_ff;
  reg  [15:0] min_ff;
  reg  [15:0] present_ff;
  reg  [15:0] max_ff;
  reg         armed_ff;
  reg         valid_ff;
  wire [15:0] run_inc = (run_ff == `STM_WORD_UMAX) ? run_ff : run_ff + 16'h0001;

  always @(posedge clk_i) begin
    if (rst_i) begin
      run_ff     <= 16'h0000;
      min_ff     <= 16'h0000;
      present_ff <= 16'h0000;
      max_ff     <= 16'h0000;
      armed_ff   <= 1'b0;
      valid_ff   <= 1'b0;
    end else if (end_rise) begin
      run_ff   <= 16'h0000;
      armed_ff <= 1'b1;
      if (armed_ff) begin
        present_ff <= run_ff;
        valid_ff   <= 1'b1;
        if (!valid_ff || run_ff < min_ff) begin
          min_ff <= run_ff;
        end
        if (!valid_ff || run_ff > max_ff) begin
          max_ff <= run_ff;
        end
      end
    end else if (tick) begin
      run_ff <= run_inc;
    end
  end

  // configuration: relay mode, timer mode, set value
  reg  [15:0] nxt_cfg;
  reg         setbad_ff;
  reg  [15:0] out_img_ff;
  wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire        rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [15:0] wdat = wb_dat_i[15:0];
  reg         sv_ok;

  always @* begin
    case (timer_mode_o)
      `STM_TMR_100MS:  sv_ok = (wdat >= `STM_TMR100_MIN) && (wdat <= `STM_TMR100_MAX);
      `STM_TMR_10MS:   sv_ok = (wdat >= `STM_TMR10_MIN) && (wdat <= `STM_TMR10_MAX);
      `STM_TMR_RET100: sv_ok = (wdat >= `STM_TMR100_MIN) && (wdat <= `STM_TMR100_MAX);
      default:         sv_ok = (wdat >= `STM_CNT_MIN) && (wdat <= `STM_CNT_MAX);
    endcase
    nxt_cfg = wdat;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_mode_o <= `STM_RELAY_NORMAL;
      timer_mode_o <= `STM_TMR_100MS;
      set_value_o  <= `STM_CFG_RESET;
      setbad_ff    <= 1'b0;
      out_img_ff   <= 16'h0000;
    end else if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        `STM_ADR_CONFIG: begin
          // latch and step settings are stored but act as plain relays
          relay_mode_o <= nxt_cfg[1:0];
          timer_mode_o <= nxt_cfg[3:2];
        end
        `STM_ADR_SETVAL: begin
          setbad_ff <= ~sv_ok;
          if (sv_ok && wb_sel_i[1]) begin
            set_value_o <= nxt_cfg;
          end
        end
        `STM_ADR_OUTIMG: begin
          out_img_ff <= nxt_cfg;
        end
        default: begin
          out_img_ff <= out_img_ff;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      out_term_o <= {OUT_WIRED{1'b0}};
    end else begin
      out_term_o <= out_img_ff[OUT_WIRED-1:0];
    end
  end

  // wishbone read mux; word data in low 16 bits, upper bits zero
  reg  [15:0] rd_word;

  always @* begin
    case (wb_adr_i)
      `STM_ADR_MIN:     rd_word = min_ff;
      `STM_ADR_PRESENT: rd_word = present_ff;
      `STM_ADR_MAX:     rd_word = max_ff;
      `STM_ADR_STATUS:  rd_word = {14'h0000, setbad_ff, valid_ff};
      `STM_ADR_CONFIG:  rd_word = {12'h000, timer_mode_o, relay_mode_o};
      `STM_ADR_SETVAL:  rd_word = set_value_o;
      `STM_ADR_INIMG:   rd_word = {{(16-IN_WIRED){1'b0}}, stable_ff[IN_WIRED-1:0]};
      `STM_ADR_OUTIMG:  rd_word = out_img_ff;
      default:          rd_word = 16'h0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= rd;
      if (rd) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

endmodule // stm_scan_monitor
`default_nettype wire

// file: sim/stm_scan_sva.sv
// handshake and output assertions for the scan time monitor
`timescale 1ns/1ps
`default_nettype none
module stm_scan_sva #(
  parameter integer OUT_WIRED = 7
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [OUT_WIRED-1:0] out_term_o,
  input wire logic [1:0]           relay_mode_o,
  input wire logic [1:0]           timer_mode_o,
  input wire logic [15:0]          set_value_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req_w = wb_cyc_i & wb_stb_i;
  wire rd_w  = wb_ack_o & ~wb_we_i;
  wire cfg_w = req_w & wb_we_i & (wb_adr_i == 8'h10);
  wire set_w = req_w & wb_we_i & (wb_adr_i == 8'h14);
  wire out_w = req_w & wb_we_i & (wb_adr_i == 8'h1C);
  AST_ACK_NEXT: assert property (req_w && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req_w && !wb_ack_o))
    else $error("ack without request");
  AST_WORD_16: assert property (rd_w |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data wider than a word");
  AST_UNMAPPED: assert property (rd_w && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_SET_RANGE: assert property (set_value_o[15] == 1'b0)
    else $error("set value above range");
  AST_SET_CAUSE: assert property ($changed(set_value_o) |-> $past(set_w) || $past(set_w, 2))
    else $error("set value changed without write");
  AST_OUT_CAUSE: assert property ($changed(out_term_o) |-> $past(out_w) || $past(out_w, 2))
    else $error("outputs changed without write");
  AST_MODE_CAUSE: assert property ($changed({relay_mode_o, timer_mode_o}) |->
    $past(cfg_w) || $past(cfg_w, 2)) else $error("mode changed without write");
  cover property (rd_w);
  cover property (set_w ##2 $changed(set_value_o));
  cover property ($changed(out_term_o));
endmodule // stm_scan_sva
bind stm_scan_monitor stm_scan_sva #(.OUT_WIRED(OUT_WIRED)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_term_o(out_term_o),
  .relay_mode_o(relay_mode_o), .timer_mode_o(timer_mode_o), .set_value_o(set_value_o));
`default_nettype wire

// file: sim/stm_scan_monitor_tb.sv
// self-checking bench for the scan time monitor
`timescale 1ns/1ps
`default_nettype none
module stm_scan_monitor_tb;
  logic        clk_i, rst_i, scan_end_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] in_term_i;
  logic [6:0]  out_term_o;
  logic [1:0]  relay_mode_o, timer_mode_o;
  logic [15:0] set_value_o, q, p;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] sv [4] = '{16'h0001, 16'h7FFF, 16'h0000, 16'h8000};
  logic [15:0] se [4] = '{16'h0001, 16'h7FFF, 16'h7FFF, 16'h7FFF};
  int          n_mismatch = 0, tests_run = 0, cnt = 0, tp = 0;
  // unit shortened to 10 clocks
  stm_scan_monitor #(.CLK_HZ(1000), .UNIT_MS(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .scan_end_i(scan_end_i), .in_term_i(in_term_i), .out_term_o(out_term_o),
    .relay_mode_o(relay_mode_o), .timer_mode_o(timer_mode_o), .set_value_o(set_value_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cnt <= cnt + 1;
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] lo, input [15:0] hi);
    tests_run++;
    if (^g === 1'bx || g < lo || g > hi) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask
  task bus(input w, input [7:0] a, input [15:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  // raise the end strobe u units after the previous one, then read present
  task scan(input int u);
    while (cnt - tp < u * 10) @(posedge clk_i);
    scan_end_i <= 1'b1;
    tp = cnt;
    repeat (2) @(posedge clk_i);
    scan_end_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    bus(1'b0, 8'h04, 16'h0000);
  endtask
  initial begin
    rst_i = 1'b1;
    scan_end_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    in_term_i = 12'hA5C;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h00, 16'h1234);
    for (int i = 0; i < 17; i++) begin
      bus(1'b0, 8'(i * 4), 16'h0000);
      chk(q, (i == 6) ? 16'h0A5C : 16'h0, (i == 6) ? 16'h0A5C : 16'h0);
    end
    $display("test reset and map done");
    scan(0);
    chk(q, 16'h0, 16'h0);
    scan(5);
    chk(q, 16'h4, 16'h6);
    p = q;
    bus(1'b0, 8'h00, 16'h0000);
    chk(q, p, p);
    bus(1'b0, 8'h08, 16'h0000);
    chk(q, p, p);
    scan(3);
    chk(q, 16'h2, 16'h4);
    scan(8);
    chk(q, 16'h7, 16'h9);
    bus(1'b0, 8'h00, 16'h0000);
    chk(q, 16'h2, 16'h4);
    bus(1'b0, 8'h08, 16'h0000);
    chk(q, 16'h7, 16'h9);
    bus(1'b0, 8'h0C, 16'h0000);
    chk({15'h0, q[0]}, 16'h1, 16'h1);
    $display("test scan time done");
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 3) continue;
      bus(1'b1, 8'h10, i[15:0]);
      chk({12'h000, timer_mode_o, relay_mode_o}, i[15:0], i[15:0]);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h14, sv[i]);
      chk(set_value_o, se[i], se[i]);
    end
    bus(1'b0, 8'h0C, 16'h0000);
    chk({15'h0, q[1]}, 16'h1, 16'h1);
    $display("test config done");
    bus(1'b1, 8'h1C, 16'hFFFF);
    chk({9'h000, out_term_o}, 16'h007F, 16'h007F);
    bus(1'b0, 8'h1C, 16'h0000);
    chk(q, 16'hFFFF, 16'hFFFF);
    bus(1'b1, 8'h1C, 16'h8000);
    bus(1'b0, 8'h1C, 16'h0000);
    chk(q, 16'h8000, 16'h8000);
    in_term_i <= 12'h5A3;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h18, 16'h0000);
    chk(q, 16'h05A3, 16'h05A3);
    $display("test images done");
    end_of_test;
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule // stm_scan_monitor_tb
`default_nettype wire
